// ---- hw/mpt_defines.svh ----
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

`define MPT_ADDR_W 8
`define MPT_CTRL 8'h00
`define MPT_PSC 8'h04
`define MPT_ARR 8'h08
`define MPT_CNT 8'h0c
`define MPT_CCMR 8'h10
`define MPT_DT 8'h14
`define MPT_STAT 8'h18
`define MPT_CLR 8'h1c
`define MPT_CCR_PAGE 4'h2
`define MPT_IEN 8'h30
`define MPT_DMAEN 8'h34

`define MPT_CTRL_EN 0
`define MPT_CTRL_DIR 1
`define MPT_CTRL_CMS 2
`define MPT_CTRL_OPM 3
`define MPT_CTRL_SMS 6:4
`define MPT_CTRL_HALL 7

`define MPT_ST_W 6
`define MPT_PIN_W 7
`define MPT_PIN_CH 3:0
`define MPT_PIN_A 4
`define MPT_PIN_B 5
`define MPT_PIN_TRG 6

`define MPT_MSK16 32'h0000_ffff
`define MPT_MSK32 32'hffff_ffff
`define MPT_ONE32 32'h0000_0001
`define MPT_ONE16 16'h0001
`define MPT_ONE8 8'h01
`define MPT_ARR_RST 32'h0000_ffff
`define MPT_RESP_OK 2'b00
`define MPT_RESP_ERR 2'b10
`endif

// ---- hw/mpt_pkg.sv ----
package mpt_pkg;
   typedef enum logic [1:0] {
      CH_OFF = 2'b00,
      CH_CAP = 2'b01,
      CH_TGL = 2'b10,
      CH_PWM = 2'b11
   } mpt_ch_mode_t;

   typedef enum logic [2:0] {
      SM_OFF = 3'b000,
      SM_ENC = 3'b001,
      SM_GATE = 3'b010,
      SM_TRIG = 3'b011,
      SM_EXT = 3'b100
   } mpt_sms_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } mpt_sync_t;

   typedef struct packed {
      logic ref_lvl;
      logic oc;
      logic ocn;
      logic [7:0] dtc;
      logic evt;
      logic [31:0] cap;
   } mpt_ch_t;

   typedef struct packed {
      logic en;
      logic dir;
      logic center;
      logic opm;
      mpt_sms_t sms;
      logic hall;
      logic [15:0] psc;
      logic [15:0] psc_cnt;
      logic [31:0] arr;
      logic [31:0] cnt;
      logic dir_dn;
      logic [7:0] ccmr;
      logic [7:0] dt;
      logic [3:0][31:0] ccr;
      logic [5:0] stat;
      logic [5:0] ien;
      logic [5:0] dmaen;
      logic enc_a_p;
      logic enc_b_p;
      logic trig_p;
      logic [3:0] ch_p;
      logic hall_p;
      logic aw_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic trgo;
      logic [5:0] dma;
      logic irq;
   } mpt_state_t;
endpackage : mpt_pkg

// ---- hw/mpt_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpt_sync (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic d_i,
   output logic q_o
);
   import mpt_pkg::*;
   mpt_sync_t s_reg, s_next;

   // a level is accepted only once stages two and three agree
   always_comb
   begin
      s_next = s_reg;
      s_next.s1 = d_i;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      if (s_reg.s2 == s_reg.s3)
      begin
         s_next.q = s_reg.s3;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign q_o = s_reg.q;
endmodule : mpt_sync
`default_nettype wire

// ---- hw/mpt_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defines.svh"
module mpt_channel (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [31:0] cnt_i,
   input wire logic [31:0] ccr_i,
   input wire mpt_pkg::mpt_ch_mode_t mode_i,
   input wire logic [7:0] dt_i,
   input wire logic step_i,
   input wire logic cap_i,
   output logic oc_o,
   output logic ocn_o,
   output logic evt_o,
   output logic [31:0] cap_o
);
   import mpt_pkg::*;
   mpt_ch_t s_reg, s_next;
   logic ref_c;

   always_comb
   begin
      s_next = s_reg;
      s_next.evt = 1'b0;
      case (mode_i)
         // compare below ccr: ccr 0 never active, ccr above arr always active
         CH_PWM: ref_c = (cnt_i < ccr_i);
         CH_TGL: ref_c = s_reg.ref_lvl ^ (step_i && cnt_i == ccr_i);
         default: ref_c = 1'b0;
      endcase
      if (mode_i == CH_CAP)
      begin
         s_next.evt = cap_i;
         if (cap_i)
         begin
            s_next.cap = cnt_i;
         end
      end
      else if (mode_i != CH_OFF)
      begin
         s_next.evt = step_i && (cnt_i == ccr_i);
      end
      s_next.ref_lvl = ref_c;
      // both sides held off for the dead time after every edge of ref
      if (ref_c != s_reg.ref_lvl && dt_i != '0)
      begin
         // the edge cycle itself is the first dead cycle
         s_next.dtc = dt_i - `MPT_ONE8;
         s_next.oc = 1'b0;
         s_next.ocn = 1'b0;
      end
      else if (s_reg.dtc != '0)
      begin
         s_next.dtc = s_reg.dtc - `MPT_ONE8;
      end
      else
      begin
         s_next.oc = ref_c;
         s_next.ocn = ~ref_c && (mode_i != CH_OFF) && (mode_i != CH_CAP);
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign oc_o = s_reg.oc;
   assign ocn_o = s_reg.ocn;
   assign evt_o = s_reg.evt;
   assign cap_o = s_reg.cap;
endmodule : mpt_channel
`default_nettype wire

// ---- hw/mpt_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defines.svh"
module mpt_timer #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] axi_awaddr_i,
   input wire logic axi_awvalid_i,
   output logic axi_awready_o,
   input wire logic [31:0] axi_wdata_i,
   input wire logic [3:0] axi_wstrb_i,
   input wire logic axi_wvalid_i,
   output logic axi_wready_o,
   output logic [1:0] axi_bresp_o,
   output logic axi_bvalid_o,
   input wire logic axi_bready_i,
   input wire logic [7:0] axi_araddr_i,
   input wire logic axi_arvalid_i,
   output logic axi_arready_o,
   output logic [31:0] axi_rdata_o,
   output logic [1:0] axi_rresp_o,
   output logic axi_rvalid_o,
   input wire logic axi_rready_i,
   input wire logic dbg_halt_i,
   input wire logic trig_i,
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic [3:0] ch_i,
   output logic [3:0] pwm_o,
   output logic [3:0] pwm_n_o,
   output logic trgo_o,
   output logic [5:0] dma_req_o,
   output logic irq_o
);
   import mpt_pkg::*;
   localparam logic [31:0] CNT_MSK = (CNT_W == 32) ? `MPT_MSK32 : `MPT_MSK16;

   mpt_state_t s_reg, s_next;
   logic [`MPT_PIN_W-1:0] pin_q;
   logic [`MPT_PIN_W-1:0] pin_raw;
   logic [3:0] ch_evt;
   logic [3:0][31:0] cap;
   logic [3:0] cap_edge;
   logic run, pre_in, tick, step, up, upd, wr, rd;
   logic trig_rise, enc_edge, enc_up, hall_edge;
   logic [31:0] cw;
   logic [5:0] evt, clr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[8*i+:8] = d[8*i+:8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         `MPT_CTRL, `MPT_PSC, `MPT_ARR, `MPT_CNT, `MPT_CCMR, `MPT_DT,
         `MPT_STAT, `MPT_CLR, `MPT_IEN, `MPT_DMAEN: ok = 1'b1;
         default: ok = (a[7:4] == `MPT_CCR_PAGE) && (a[1:0] == 2'b00);
      endcase
      return ok;
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////////
   assign pin_raw = {trig_i, enc_b_i, enc_a_i, ch_i};

   genvar g;
   generate
      for (g = 0; g < `MPT_PIN_W; g++)
      begin : g_sync
         mpt_sync u_sync (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .d_i(pin_raw[g]),
            .q_o(pin_q[g])
         );
      end
      for (g = 0; g < 4; g++)
      begin : g_ch
         // hall mode steers the xor of all sensor lines onto channel 0
         assign cap_edge[g] = (g == 0 && s_reg.hall) ? hall_edge
                              : (pin_q[g] & ~s_reg.ch_p[g]);
         mpt_channel u_ch (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .cnt_i(s_reg.cnt),
            .ccr_i(s_reg.ccr[g]),
            .mode_i(mpt_ch_mode_t'(s_reg.ccmr[2*g+:2])),
            .dt_i(s_reg.dt),
            .step_i(step),
            .cap_i(cap_edge[g]),
            .oc_o(pwm_o[g]),
            .ocn_o(pwm_n_o[g]),
            .evt_o(ch_evt[g]),
            .cap_o(cap[g])
         );
      end
   endgenerate

   assign hall_edge = (^pin_q[`MPT_PIN_CH]) != s_reg.hall_p;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_next = s_reg;
      cw = '0;
      clr = '0;
      trig_rise = pin_q[`MPT_PIN_TRG] & ~s_reg.trig_p;
      enc_edge = (pin_q[`MPT_PIN_A] ^ s_reg.enc_a_p) | (pin_q[`MPT_PIN_B] ^ s_reg.enc_b_p);
      enc_up = pin_q[`MPT_PIN_A] ^ s_reg.enc_b_p;
      case (s_reg.sms)
         SM_EXT: pre_in = trig_rise;
         SM_GATE: pre_in = pin_q[`MPT_PIN_TRG];
         default: pre_in = 1'b1;
      endcase
      run = s_reg.en & ~dbg_halt_i;
      tick = run && pre_in && (s_reg.sms != SM_ENC) && (s_reg.psc_cnt >= s_reg.psc);
      step = (s_reg.sms == SM_ENC) ? (run & enc_edge) : tick;
      if (s_reg.sms == SM_ENC)
      begin
         up = enc_up;
      end
      else
      begin
         up = s_reg.center ? ~s_reg.dir_dn : ~s_reg.dir;
      end
      if (run && pre_in)
      begin
         s_next.psc_cnt = (s_reg.psc_cnt >= s_reg.psc) ? '0 : s_reg.psc_cnt + `MPT_ONE16;
      end
      upd = 1'b0;
      if (step)
      begin
         if (up)
         begin
            if (s_reg.cnt >= s_reg.arr)
            begin
               upd = 1'b1;
               if (s_reg.center && s_reg.sms != SM_ENC)
               begin
                  s_next.cnt = s_reg.arr - `MPT_ONE32;
                  s_next.dir_dn = 1'b1;
               end
               else
               begin
                  s_next.cnt = '0;
               end
            end
            else
            begin
               s_next.cnt = s_reg.cnt + `MPT_ONE32;
            end
         end
         else if (s_reg.cnt == '0)
         begin
            upd = 1'b1;
            if (s_reg.center && s_reg.sms != SM_ENC)
            begin
               s_next.cnt = `MPT_ONE32;
               s_next.dir_dn = 1'b0;
            end
            else
            begin
               s_next.cnt = s_reg.arr;
            end
         end
         else
         begin
            s_next.cnt = s_reg.cnt - `MPT_ONE32;
         end
      end
      if (upd && s_reg.opm)
      begin
         s_next.en = 1'b0;
      end
      if (s_reg.sms == SM_TRIG && trig_rise)
      begin
         s_next.en = 1'b1;
      end
      s_next.trig_p = pin_q[`MPT_PIN_TRG];
      s_next.enc_a_p = pin_q[`MPT_PIN_A];
      s_next.enc_b_p = pin_q[`MPT_PIN_B];
      s_next.ch_p = pin_q[`MPT_PIN_CH];
      s_next.hall_p = ^pin_q[`MPT_PIN_CH];

      // write channel: address and data are accepted in the same cycle
      s_next.aw_rdy = !s_reg.aw_rdy && !s_reg.bvalid && axi_awvalid_i && axi_wvalid_i;
      wr = s_reg.aw_rdy && axi_awvalid_i && axi_wvalid_i;
      if (s_reg.bvalid && axi_bready_i)
      begin
         s_next.bvalid = 1'b0;
      end
      if (wr)
      begin
         s_next.bvalid = 1'b1;
         s_next.bresp = mapped(axi_awaddr_i) ? `MPT_RESP_OK : `MPT_RESP_ERR;
         case (axi_awaddr_i)
            `MPT_CTRL:
            begin
               cw[`MPT_CTRL_EN] = s_reg.en;
               cw[`MPT_CTRL_DIR] = s_reg.dir;
               cw[`MPT_CTRL_CMS] = s_reg.center;
               cw[`MPT_CTRL_OPM] = s_reg.opm;
               cw[`MPT_CTRL_SMS] = s_reg.sms;
               cw[`MPT_CTRL_HALL] = s_reg.hall;
               cw = merge(cw, axi_wdata_i, axi_wstrb_i);
               s_next.en = cw[`MPT_CTRL_EN];
               s_next.dir = cw[`MPT_CTRL_DIR];
               s_next.center = cw[`MPT_CTRL_CMS];
               s_next.opm = cw[`MPT_CTRL_OPM];
               s_next.sms = mpt_sms_t'(cw[`MPT_CTRL_SMS]);
               s_next.hall = cw[`MPT_CTRL_HALL];
            end
            `MPT_PSC: s_next.psc = 16'(merge({16'h0000, s_reg.psc}, axi_wdata_i, axi_wstrb_i));
            `MPT_ARR: s_next.arr = merge(s_reg.arr, axi_wdata_i, axi_wstrb_i) & CNT_MSK;
            `MPT_CNT: s_next.cnt = merge(s_reg.cnt, axi_wdata_i, axi_wstrb_i) & CNT_MSK;
            `MPT_CCMR: s_next.ccmr = 8'(merge({24'h00_0000, s_reg.ccmr}, axi_wdata_i,
                                              axi_wstrb_i));
            `MPT_DT: s_next.dt = 8'(merge({24'h00_0000, s_reg.dt}, axi_wdata_i, axi_wstrb_i));
            `MPT_CLR: clr = 6'(merge('0, axi_wdata_i, axi_wstrb_i));
            `MPT_IEN: s_next.ien = 6'(merge('0, axi_wdata_i, axi_wstrb_i));
            `MPT_DMAEN: s_next.dmaen = 6'(merge('0, axi_wdata_i, axi_wstrb_i));
            default:
            begin
               if (mapped(axi_awaddr_i) && axi_awaddr_i[7:4] == `MPT_CCR_PAGE)
               begin
                  s_next.ccr[axi_awaddr_i[3:2]] =
                     merge(s_reg.ccr[axi_awaddr_i[3:2]], axi_wdata_i, axi_wstrb_i) & CNT_MSK;
               end
            end
         endcase
      end

      // read channel
      s_next.ar_rdy = !s_reg.ar_rdy && !s_reg.rvalid && axi_arvalid_i;
      rd = s_reg.ar_rdy && axi_arvalid_i;
      if (s_reg.rvalid && axi_rready_i)
      begin
         s_next.rvalid = 1'b0;
      end
      if (rd)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp = mapped(axi_araddr_i) ? `MPT_RESP_OK : `MPT_RESP_ERR;
         s_next.rdata = '0;
         case (axi_araddr_i)
            `MPT_CTRL:
            begin
               s_next.rdata[`MPT_CTRL_EN] = s_reg.en;
               s_next.rdata[`MPT_CTRL_DIR] = s_reg.center ? s_reg.dir_dn : s_reg.dir;
               s_next.rdata[`MPT_CTRL_CMS] = s_reg.center;
               s_next.rdata[`MPT_CTRL_OPM] = s_reg.opm;
               s_next.rdata[`MPT_CTRL_SMS] = s_reg.sms;
               s_next.rdata[`MPT_CTRL_HALL] = s_reg.hall;
            end
            `MPT_PSC: s_next.rdata[15:0] = s_reg.psc;
            `MPT_ARR: s_next.rdata = s_reg.arr;
            `MPT_CNT: s_next.rdata = s_reg.cnt;
            `MPT_CCMR: s_next.rdata[7:0] = s_reg.ccmr;
            `MPT_DT: s_next.rdata[7:0] = s_reg.dt;
            `MPT_STAT: s_next.rdata[5:0] = s_reg.stat;
            `MPT_IEN: s_next.rdata[5:0] = s_reg.ien;
            `MPT_DMAEN: s_next.rdata[5:0] = s_reg.dmaen;
            default:
            begin
               // captured value replaces the compare value in capture mode
               if (mapped(axi_araddr_i) && axi_araddr_i[7:4] == `MPT_CCR_PAGE)
               begin
                  s_next.rdata = (s_reg.ccmr[2*axi_araddr_i[3:2]+:2] == CH_CAP)
                                 ? cap[axi_araddr_i[3:2]] : s_reg.ccr[axi_araddr_i[3:2]];
               end
            end
         endcase
      end

      // a new event beats a clear of the same bit
      evt = {trig_rise, ch_evt, upd};
      s_next.stat = (s_reg.stat & ~clr) | evt;
      s_next.dma = evt & s_next.dmaen;
      s_next.trgo = upd;
      s_next.irq = |(s_next.stat & s_next.ien);
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_reg <= '0;
         s_reg.arr <= `MPT_ARR_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign axi_awready_o = s_reg.aw_rdy;
   assign axi_wready_o = s_reg.aw_rdy;
   assign axi_bvalid_o = s_reg.bvalid;
   assign axi_bresp_o = s_reg.bresp;
   assign axi_arready_o = s_reg.ar_rdy;
   assign axi_rvalid_o = s_reg.rvalid;
   assign axi_rresp_o = s_reg.rresp;
   assign axi_rdata_o = s_reg.rdata;
   assign trgo_o = s_reg.trgo;
   assign dma_req_o = s_reg.dma;
   assign irq_o = s_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_wrap_up;
      step && up && !s_reg.center && s_reg.cnt >= s_reg.arr && !wr |=> s_reg.cnt == '0;
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("up wrap did not clear count");

   property p_psc;
      tick |=> s_reg.psc_cnt == '0;
   endproperty
   a_psc: assert property (p_psc) else $error("prescaler not restarted");

   property p_opm;
      upd && s_reg.opm && s_reg.sms != SM_TRIG && !wr |=> !s_reg.en;
   endproperty
   a_opm: assert property (p_opm) else $error("one pulse did not stop");

   property p_center;
      step && up && s_reg.center && s_reg.sms != SM_ENC && s_reg.cnt >= s_reg.arr && !wr
         |=> s_reg.dir_dn;
   endproperty
   a_center: assert property (p_center) else $error("center mode did not turn");

   property p_halt;
      dbg_halt_i && !wr |=> $stable(s_reg.cnt);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved while halted");

   property p_trgo;
      upd |=> trgo_o ##1 !trgo_o || $past(upd);
   endproperty
   a_trgo: assert property (p_trgo) else $error("trigger out missing");

   property p_dma;
      upd && s_next.dmaen[0] |=> dma_req_o[0];
   endproperty
   a_dma: assert property (p_dma) else $error("update dma request missing");

   property p_enc;
      s_reg.sms == SM_ENC && step && enc_up && s_reg.cnt < s_reg.arr && !wr
         |=> s_reg.cnt == $past(s_reg.cnt) + `MPT_ONE32;
   endproperty
   a_enc: assert property (p_enc) else $error("encoder step up lost");

   property p_upd;
      upd |=> s_reg.stat[0] ##1 (irq_o || !s_reg.ien[0]);
   endproperty
   a_upd: assert property (p_upd) else $error("update flag not raised");

   property p_cov_upd;
      upd;
   endproperty
   c_upd: cover property (p_cov_upd);

   property p_cov_enc;
      s_reg.sms == SM_ENC && step;
   endproperty
   c_enc: cover property (p_cov_enc);

   property p_cov_cap;
      |ch_evt ##1 irq_o;
   endproperty
   c_cap: cover property (p_cov_cap);
endmodule : mpt_timer
`default_nettype wire

// ---- dv/mpt_sensor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpt_sensor_model (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic step_i,
   input wire logic back_i,
   input wire logic trig_set_i,
   input wire logic [3:0] ch_set_i,
   output logic enc_a_o,
   output logic enc_b_o,
   output logic trig_o,
   output logic [3:0] ch_o
);
   logic [1:0] phase_reg;
   // gray sequence, a leads b when running forward
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         phase_reg <= 2'h0;
         ch_o <= 4'h0;
         trig_o <= 1'b0;
      end
      else
      begin
         if (step_i)
            phase_reg <= back_i ? phase_reg - 2'h1 : phase_reg + 2'h1;
         ch_o <= ch_set_i;
         trig_o <= trig_set_i;
      end
   end
   assign enc_a_o = phase_reg[1] ^ phase_reg[0];
   assign enc_b_o = phase_reg[1];
endmodule : mpt_sensor_model
`default_nettype wire

// ---- dv/motor_pwm_capture_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defines.svh"
module motor_pwm_capture_timer_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, trgo, irq, enc_a, enc_b, trig;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd, v;
   logic dbg_halt = 1'b0, step = 1'b0, back = 1'b0, trig_set = 1'b0;
   logic [3:0] ch_set = 4'h0, pwm, pwm_n, ch;
   logic [5:0] dma;
   logic [31:0] seed = 32'h0000_000a;
   int errors = 0, n_checks = 0, cycles = 0;
   int k, p, a, n_t, n_d, hi, lo, z;

   mpt_timer #(.CNT_W(16)) mpt_timer_i (.core_clk_i(clk), .rst_b_i(rst_b),
      .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
      .axi_wdata_i(wdata), .axi_wstrb_i(4'hf), .axi_wvalid_i(wvalid), .axi_wready_o(wready),
      .axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
      .axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
      .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
      .dbg_halt_i(dbg_halt), .trig_i(trig), .enc_a_i(enc_a), .enc_b_i(enc_b), .ch_i(ch),
      .pwm_o(pwm), .pwm_n_o(pwm_n), .trgo_o(trgo), .dma_req_o(dma), .irq_o(irq));
   mpt_sensor_model mpt_sensor_model_i (.core_clk_i(clk), .rst_b_i(rst_b), .step_i(step),
      .back_i(back), .trig_set_i(trig_set), .ch_set_i(ch_set), .enc_a_o(enc_a),
      .enc_b_o(enc_b), .trig_o(trig), .ch_o(ch));

   initial
   begin
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int duty(input int ccr, input int arr, input int n);
      return (ccr > arr) ? n : ccr * n / (arr + 1);
   endfunction : duty
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // master keeps bready up from the start; a spare edge keeps drivers single per step
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rdr(input logic [7:0] ad);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rdr

   // ceiling well above the thousand or so cycles the sequence needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdr(`MPT_ARR);
      chk(rd, `MPT_ARR_RST, "arr reset");
      rdr(8'h3c);
      chk(rsp, 32'h0000_0002, "unmapped read");
      wr(8'h3c, 32'h0000_0001);
      chk(rsp, 32'h0000_0002, "unmapped write");
      for (k = 0; k < 4; k++)
      begin
         v = xs();
         wr(`MPT_CNT, v);
         rdr(`MPT_CNT);
         chk(rd, v & `MPT_MSK16, "count width");
      end
      $display("test registers done");
      for (k = 0; k < 3; k++)
      begin
         p = xs() % 4;
         a = 3 + xs() % 8;
         wr(`MPT_PSC, p);
         wr(`MPT_ARR, a);
         wr(`MPT_IEN, 32'h0000_0001);
         wr(`MPT_DMAEN, 32'h0000_0001);
         wr(`MPT_CNT, 32'h0000_0000);
         wr(`MPT_CTRL, 32'h0000_0001);
         n_t = 0;
         n_d = 0;
         repeat (4 * (a + 1) * (p + 1))
         begin
            @(posedge clk);
            n_t += trgo;
            n_d += dma[0];
         end
         chk(n_t, 4, "update count");
         chk(n_d, 4, "dma count");
         chk(irq, 1'b1, "irq set");
         wr(`MPT_CTRL, 32'h0000_0000);
         wr(`MPT_CLR, 32'h0000_0001);
         repeat (3) @(posedge clk);
         chk(irq, 1'b0, "irq cleared");
      end
      $display("test reload done");
      wr(`MPT_PSC, 32'h0000_0000);
      wr(`MPT_ARR, 32'h0000_ffff);
      wr(`MPT_CTRL, 32'h0000_0001);
      dbg_halt <= 1'b1;
      repeat (2) @(posedge clk);
      rdr(`MPT_CNT);
      v = rd;
      repeat (20) @(posedge clk);
      rdr(`MPT_CNT);
      chk(rd, v, "frozen");
      dbg_halt <= 1'b0;
      repeat (20) @(posedge clk);
      rdr(`MPT_CNT);
      chk(rd > v, 1'b1, "resumed");
      $display("test halt done");
      wr(`MPT_ARR, 32'h0000_0009);
      wr(`MPT_CCMR, 32'h0000_0003);
      for (k = 0; k < 4; k++)
      begin
         wr(`MPT_DT, (k == 3) ? 32'h0000_0002 : 32'h0000_0000);
         wr({`MPT_CCR_PAGE, 4'h0}, (k == 3) ? 32'h0000_0005 : 5 * k);
         repeat (6) @(posedge clk);
         hi = 0;
         lo = 0;
         z = 0;
         repeat (20)
         begin
            @(posedge clk);
            hi += pwm[0];
            lo += pwm_n[0];
            z += (!pwm[0] && !pwm_n[0]);
         end
         if (k < 3)
         begin
            chk(hi, duty(5 * k, 9, 20), "duty");
            chk(lo, 20 - duty(5 * k, 9, 20), "complement");
         end
         chk(z, (k == 3) ? 8 : 0, "dead time");
      end
      wr(`MPT_CTRL, 32'h0000_0000);
      $display("test pwm done");
      wr(`MPT_ARR, 32'h0000_ffff);
      wr(`MPT_CNT, 32'h0000_0000);
      wr(`MPT_CTRL, 32'h0000_0011);
      for (k = 0; k < 11; k++)
      begin
         back <= (k >= 8);
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         repeat (7) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      rdr(`MPT_CNT);
      chk(rd, 32'h0000_0005, "encoder");
      wr(`MPT_CTRL, 32'h0000_0000);
      wr(`MPT_ARR, 32'h0000_0003);
      wr(`MPT_CNT, 32'h0000_0002);
      wr(`MPT_CTRL, 32'h0000_000b);
      repeat (10) @(posedge clk);
      rdr(`MPT_CTRL);
      chk(rd, 32'h0000_000a, "one pulse down");
      wr(`MPT_CTRL, 32'h0000_0005);
      n_t = 0;
      repeat (30)
      begin
         @(posedge clk);
         n_t += trgo;
      end
      chk(n_t, 10, "center updates");
      wr(`MPT_CTRL, 32'h0000_0000);
      $display("test encoder done");
      wr(`MPT_CCMR, 32'h0000_0004);
      wr(`MPT_CLR, 32'h0000_003f);
      ch_set <= 4'h2;
      repeat (10) @(posedge clk);
      rdr(`MPT_STAT);
      chk(rd[2], 1'b1, "capture");
      wr(`MPT_CCMR, 32'h0000_0001);
      wr(`MPT_CTRL, 32'h0000_0080);
      wr(`MPT_CLR, 32'h0000_003f);
      ch_set <= 4'ha;
      repeat (10) @(posedge clk);
      rdr(`MPT_STAT);
      chk(rd[1], 1'b1, "hall");
      trig_set <= 1'b1;
      repeat (10) @(posedge clk);
      rdr(`MPT_STAT);
      chk(rd[5], 1'b1, "trigger");
      $display("test inputs done");
      test_done();
   end
endmodule : motor_pwm_capture_timer_test
`default_nettype wire
